// [src/tec_fault_monitor.sv]
/*
 * tec_fault_monitor: heatsink sensor, tuning, fan, stability and watchdog
 * supervision with a latched first error number and a halt output.
 * Assumes all measurement inputs come from logic on SYS_CLK_IN; registers
 * are reached over AXI4-Lite.
 */
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
module tec_fault_monitor import tec_fault_pkg::*; #(
   parameter int unsigned TICK_LEN = TICK_CYCLES,          // cycles per timeout tick
   parameter int unsigned FAN_SLOW_LEN = FAN_SLOW_CYCLES,  // fan slow hold cycles
   parameter int unsigned FAN_STOP_LEN = FAN_STOP_CYCLES   // fan stop hold cycles
) (
   input wire logic SYS_CLK_IN,               // system clock
   input wire logic RSTN_IN,                  // async reset, active low
   input wire logic [7:0] S_AXI_AWADDR_IN,    // write address
   input wire logic S_AXI_AWVALID_IN,         // write address valid
   output logic S_AXI_AWREADY_OUT,            // write address ready
   input wire logic [31:0] S_AXI_WDATA_IN,    // write data
   input wire logic [3:0] S_AXI_WSTRB_IN,     // byte strobes
   input wire logic S_AXI_WVALID_IN,          // write data valid
   output logic S_AXI_WREADY_OUT,             // write data ready
   output logic [1:0] S_AXI_BRESP_OUT,        // write response
   output logic S_AXI_BVALID_OUT,             // write response valid
   input wire logic S_AXI_BREADY_IN,          // write response ready
   input wire logic [7:0] S_AXI_ARADDR_IN,    // read address
   input wire logic S_AXI_ARVALID_IN,         // read address valid
   output logic S_AXI_ARREADY_OUT,            // read address ready
   output logic [31:0] S_AXI_RDATA_OUT,       // read data
   output logic [1:0] S_AXI_RRESP_OUT,        // read response
   output logic S_AXI_RVALID_OUT,             // read data valid
   input wire logic S_AXI_RREADY_IN,          // read data ready
   input wire logic MEAS_VALID_IN,            // one pulse per measurement cycle
   input wire logic [11:0] SINK_ADC_IN,       // heatsink adc raw value
   input wire logic [15:0] SINK_TEMP_IN,      // heatsink temperature, signed
   input wire logic TUNE_RUN_IN,              // auto-tuning active
   input wire logic TUNE_DONE_IN,             // tuning attempt finished, pulse
   input wire logic [7:0] TUNE_TEMP_DISC_IN,  // temperature discrepancy, percent
   input wire logic [7:0] TUNE_PER_DISC_IN,   // period discrepancy, percent
   input wire logic REG_LIMIT_IN,             // regulator at output limit
   input wire logic REG_RUN_IN,               // regulator running
   input wire logic [7:0] FAN_PWM_IN,         // fan pwm level, percent
   input wire logic [15:0] FAN_SPEED_IN,      // measured fan speed
   input wire logic STABLE_IN,                // temperature stable
   input wire logic PKT_RX_IN,                // packet received, pulse
   output logic [7:0] ERR_CODE_OUT,           // latched first error number
   output logic FAULT_OUT,                    // error latched
   output logic HALT_OUT                      // halt controller output
);

   // merge written bytes into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   // lowest error code among active conditions
   function automatic logic [7:0] pick(input logic [NUM_COND-1:0] c);
      logic [7:0] codes [NUM_COND];
      logic [7:0] res;
      codes = '{ERR_ADC_LOW, ERR_ADC_HIGH, ERR_TEMP_LOW, ERR_TEMP_HIGH, ERR_TEMP_RATE,
         ERR_TUNE_TEMP, ERR_TUNE_PERIOD, ERR_TUNE_REG, ERR_FAN_SLOW, ERR_FAN_STOP,
         ERR_STAB, ERR_WDOG};
      res = ERR_NONE;
      for (int i = NUM_COND - 1; i >= 0; i--) begin
         if (c[i]) begin
            res = codes[i];
         end
      end
      return res;
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   cfg_t cfg;
   sink_meas_t prev;
   logic have_prev;
   logic prev_dir;
   logic [4:0] rate_cnt;
   logic [1:0] tune_fails;
   logic tune_temp_bad;
   logic tune_per_bad;
   logic [31:0] tick_cnt;
   logic tick;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] next_rdata;
   logic [NUM_COND-1:0] cond;

   // write channel decode
   wire do_write = !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT && !S_AXI_BVALID_OUT;
   wire wr_ctrl = do_write && is_addr(aw_addr, OFS_CTRL);
   wire wr_err = do_write && is_addr(aw_addr, OFS_ERR);
   wire wr_low = do_write && is_addr(aw_addr, OFS_LOW_THR);
   wire wr_high = do_write && is_addr(aw_addr, OFS_HIGH_THR);
   wire wr_chg = do_write && is_addr(aw_addr, OFS_MAX_CHG);
   wire wr_nom = do_write && is_addr(aw_addr, OFS_FAN_NOM);
   wire wr_stab = do_write && is_addr(aw_addr, OFS_STAB_TO);
   wire wr_wdog = do_write && is_addr(aw_addr, OFS_WDOG_TO);
   wire wr_hit = wr_ctrl || wr_err || wr_low || wr_high || wr_chg || wr_nom || wr_stab || wr_wdog
      || is_addr(aw_addr, OFS_COND);
   wire err_clear = wr_err && w_strb[1] && w_data[ERR_VALID_BIT];

   // sink measurement arithmetic
   wire signed [16:0] delta = $signed({SINK_TEMP_IN[15], SINK_TEMP_IN}) - $signed({prev.temp[15], prev.temp});
   wire [16:0] delta_abs = delta[16] ? 17'(-delta) : 17'(delta);
   wire fast = have_prev && (delta_abs > {1'b0, cfg.max_chg});
   wire dir = delta[16];
   wire tune_fail = (TUNE_TEMP_DISC_IN > TUNE_DISC_PCT) || (TUNE_PER_DISC_IN > TUNE_DISC_PCT);
   wire [23:0] fan_meas_pct = 24'(FAN_SPEED_IN) * 24'(PWM_FULL_PCT);
   wire [23:0] fan_need_pct = 24'(cfg.fan_nom) * 24'(FAN_SLOW_PCT);
   wire fan_slow_now = (FAN_PWM_IN == PWM_FULL_PCT) && (fan_meas_pct < fan_need_pct);
   wire fan_stop_now = (FAN_SPEED_IN == 16'h0000) && (FAN_PWM_IN > PWM_STOP_PCT);
   wire stab_wait = cfg.stab_arm && !STABLE_IN;
   wire wdog_wait = !PKT_RX_IN;
   wire fan_slow_hit;
   wire fan_stop_hit;
   wire stab_hit;
   wire wdog_hit;
   wire [7:0] new_code = pick(cond);
   wire any_err = cfg.enable && (new_code != ERR_NONE);

   // present fault conditions, bit order follows code order
   assign cond[0] = prev.adc < ADC_LOW_LIMIT;
   assign cond[1] = prev.adc > ADC_HIGH_LIMIT;
   assign cond[2] = have_prev && ($signed(prev.temp) < $signed(cfg.low_thr));
   assign cond[3] = have_prev && ($signed(prev.temp) > $signed(cfg.high_thr));
   assign cond[4] = rate_cnt == RATE_RUN_LEN;
   assign cond[5] = (tune_fails == TUNE_FAIL_RUN) && tune_temp_bad;
   assign cond[6] = (tune_fails == TUNE_FAIL_RUN) && tune_per_bad;
   assign cond[7] = TUNE_RUN_IN && (REG_LIMIT_IN || !REG_RUN_IN);
   assign cond[8] = fan_slow_hit;
   assign cond[9] = fan_stop_hit;
   assign cond[10] = stab_hit;
   assign cond[11] = wdog_hit;
   assign tick = tick_cnt == 32'(TICK_LEN - 1);

   // fan and timeout hold timers
   hold_timer u_fan_slow (
      .clk(SYS_CLK_IN), .rst_n(RSTN_IN), .cond(fan_slow_now), .tick(1'b1),
      .limit(32'(FAN_SLOW_LEN)), .hit(fan_slow_hit)
   );
   hold_timer u_fan_stop (
      .clk(SYS_CLK_IN), .rst_n(RSTN_IN), .cond(fan_stop_now), .tick(1'b1),
      .limit(32'(FAN_STOP_LEN)), .hit(fan_stop_hit)
   );
   hold_timer u_stab (
      .clk(SYS_CLK_IN), .rst_n(RSTN_IN), .cond(stab_wait), .tick(tick),
      .limit(cfg.stab_to), .hit(stab_hit)
   );
   hold_timer u_wdog (
      .clk(SYS_CLK_IN), .rst_n(RSTN_IN), .cond(wdog_wait), .tick(tick),
      .limit(cfg.wdog_to), .hit(wdog_hit)
   );

   // timeout tick prescaler
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      end
   end

   // capture each measurement and track same-direction fast changes
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         prev <= '{adc: 12'h800, temp: 16'h0000};
         have_prev <= 1'b0;
         prev_dir <= 1'b0;
         rate_cnt <= 5'h00;
      end else if (MEAS_VALID_IN) begin
         prev <= '{adc: SINK_ADC_IN, temp: SINK_TEMP_IN};
         have_prev <= 1'b1;
         prev_dir <= dir;
         if (!fast) begin
            rate_cnt <= 5'h00;
         end else if (rate_cnt != 5'h00 && dir != prev_dir) begin
            rate_cnt <= 5'h01;
         end else if (rate_cnt != RATE_RUN_LEN) begin
            rate_cnt <= rate_cnt + 5'h01;
         end
      end
   end

   // consecutive tuning failures
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         tune_fails <= 2'h0;
         tune_temp_bad <= 1'b0;
         tune_per_bad <= 1'b0;
      end else if (TUNE_DONE_IN) begin
         tune_temp_bad <= TUNE_TEMP_DISC_IN > TUNE_DISC_PCT;
         tune_per_bad <= TUNE_PER_DISC_IN > TUNE_DISC_PCT;
         if (!tune_fail) begin
            tune_fails <= 2'h0;
         end else if (tune_fails != TUNE_FAIL_RUN) begin
            tune_fails <= tune_fails + 2'h1;
         end
      end
   end

   // first error latch, a new error wins over a clear in the same cycle
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ERR_CODE_OUT <= ERR_NONE;
         FAULT_OUT <= 1'b0;
         HALT_OUT <= 1'b0;
      end else if (any_err && (!FAULT_OUT || err_clear)) begin
         ERR_CODE_OUT <= new_code;
         FAULT_OUT <= 1'b1;
         HALT_OUT <= 1'b1;
      end else if (err_clear) begin
         ERR_CODE_OUT <= ERR_NONE;
         FAULT_OUT <= 1'b0;
         HALT_OUT <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         cfg <= CFG_RESET;
      end else begin
         if (wr_ctrl && w_strb[0]) begin
            cfg.enable <= w_data[CTRL_EN_BIT];
            cfg.stab_arm <= w_data[CTRL_STAB_ARM_BIT];
         end
         if (wr_low) cfg.low_thr <= 16'(merge({16'h0000, cfg.low_thr}, w_data, w_strb));
         if (wr_high) cfg.high_thr <= 16'(merge({16'h0000, cfg.high_thr}, w_data, w_strb));
         if (wr_chg) cfg.max_chg <= 16'(merge({16'h0000, cfg.max_chg}, w_data, w_strb));
         if (wr_nom) cfg.fan_nom <= 16'(merge({16'h0000, cfg.fan_nom}, w_data, w_strb));
         if (wr_stab) cfg.stab_to <= merge(cfg.stab_to, w_data, w_strb);
         if (wr_wdog) cfg.wdog_to <= merge(cfg.wdog_to, w_data, w_strb);
      end
   end

   // axi write address, data and response
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         S_AXI_AWREADY_OUT <= 1'b1;
         S_AXI_WREADY_OUT <= 1'b1;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (S_AXI_AWREADY_OUT && S_AXI_AWVALID_IN) begin
            S_AXI_AWREADY_OUT <= 1'b0;
            aw_addr <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WREADY_OUT && S_AXI_WVALID_IN) begin
            S_AXI_WREADY_OUT <= 1'b0;
            w_data <= S_AXI_WDATA_IN;
            w_strb <= S_AXI_WSTRB_IN;
         end
         if (do_write) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_AWREADY_OUT <= 1'b1;
            S_AXI_WREADY_OUT <= 1'b1;
         end
      end
   end

   // read data selection
   always_comb begin
      if (is_addr(S_AXI_ARADDR_IN, OFS_CTRL)) begin
         next_rdata = {30'h0000_0000, cfg.stab_arm, cfg.enable};
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_ERR)) begin
         next_rdata = {23'h00_0000, FAULT_OUT, ERR_CODE_OUT};
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_LOW_THR)) begin
         next_rdata = {16'h0000, cfg.low_thr};
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_HIGH_THR)) begin
         next_rdata = {16'h0000, cfg.high_thr};
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_MAX_CHG)) begin
         next_rdata = {16'h0000, cfg.max_chg};
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_FAN_NOM)) begin
         next_rdata = {16'h0000, cfg.fan_nom};
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_STAB_TO)) begin
         next_rdata = cfg.stab_to;
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_WDOG_TO)) begin
         next_rdata = cfg.wdog_to;
      end else if (is_addr(S_AXI_ARADDR_IN, OFS_COND)) begin
         next_rdata = {20'h0_0000, cond};
      end else begin
         next_rdata = 32'h0000_0000;
      end
   end

   wire rd_hit = S_AXI_ARADDR_IN <= OFS_COND && S_AXI_ARADDR_IN[1:0] == 2'h0;

   // axi read channel, answer one cycle after the address is taken
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         S_AXI_ARREADY_OUT <= 1'b1;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h0000_0000;
         S_AXI_RRESP_OUT <= RESP_OKAY;
      end else if (S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT <= 1'b1;
         S_AXI_RDATA_OUT <= next_rdata;
         S_AXI_RRESP_OUT <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_ARREADY_OUT <= 1'b1;
      end
   end

endmodule

// [src/tec_fault_pkg.sv]
/*
 * tec_fault_pkg: register map, field layout, reset values, error codes and
 * timing constants of the heatsink / fan / tuning fault monitor.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package tec_fault_pkg;

   // clock and time base
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned TICK_TIME_US = 1_000;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int unsigned FAN_SLOW_TIME_S = 12;
   localparam int unsigned FAN_SLOW_CYCLES = FAN_SLOW_TIME_S * CLK_HZ;
   localparam int unsigned FAN_STOP_TIME_S = 10;
   localparam int unsigned FAN_STOP_CYCLES = FAN_STOP_TIME_S * CLK_HZ;

   // fixed thresholds
   localparam logic [11:0] ADC_LOW_LIMIT = 12'h028;
   localparam logic [11:0] ADC_HIGH_LIMIT = 12'hfd2;
   localparam logic [4:0] RATE_RUN_LEN = 5'h14;
   localparam logic [7:0] TUNE_DISC_PCT = 8'h28;
   localparam logic [1:0] TUNE_FAIL_RUN = 2'h3;
   localparam logic [7:0] PWM_FULL_PCT = 8'h64;
   localparam logic [7:0] PWM_STOP_PCT = 8'h23;
   localparam logic [7:0] FAN_SLOW_PCT = 8'h3c;

   // error codes
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_ADC_LOW = 8'h8c;
   localparam logic [7:0] ERR_ADC_HIGH = 8'h8d;
   localparam logic [7:0] ERR_TEMP_LOW = 8'h8e;
   localparam logic [7:0] ERR_TEMP_HIGH = 8'h8f;
   localparam logic [7:0] ERR_TEMP_RATE = 8'h90;
   localparam logic [7:0] ERR_TUNE_TEMP = 8'hab;
   localparam logic [7:0] ERR_TUNE_PERIOD = 8'hac;
   localparam logic [7:0] ERR_TUNE_REG = 8'had;
   localparam logic [7:0] ERR_FAN_SLOW = 8'haf;
   localparam logic [7:0] ERR_FAN_STOP = 8'hb0;
   localparam logic [7:0] ERR_STAB = 8'hb6;
   localparam logic [7:0] ERR_WDOG = 8'hb7;
   localparam int unsigned NUM_COND = 12;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ERR = 8'h04;
   localparam logic [7:0] OFS_LOW_THR = 8'h08;
   localparam logic [7:0] OFS_HIGH_THR = 8'h0c;
   localparam logic [7:0] OFS_MAX_CHG = 8'h10;
   localparam logic [7:0] OFS_FAN_NOM = 8'h14;
   localparam logic [7:0] OFS_STAB_TO = 8'h18;
   localparam logic [7:0] OFS_WDOG_TO = 8'h1c;
   localparam logic [7:0] OFS_COND = 8'h20;

   // field positions
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_STAB_ARM_BIT = 1;
   localparam int unsigned ERR_VALID_BIT = 8;

   // reset values
   localparam logic [15:0] RST_LOW_THR = 16'hff00;
   localparam logic [15:0] RST_HIGH_THR = 16'h0500;
   localparam logic [15:0] RST_MAX_CHG = 16'h0010;
   localparam logic [15:0] RST_FAN_NOM = 16'h0bb8;
   localparam logic [31:0] RST_STAB_TO = 32'h0000_0000;
   localparam logic [31:0] RST_WDOG_TO = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // software configuration carried as one bundle
   typedef struct packed {
      logic enable;
      logic stab_arm;
      logic [15:0] low_thr;
      logic [15:0] high_thr;
      logic [15:0] max_chg;
      logic [15:0] fan_nom;
      logic [31:0] stab_to;
      logic [31:0] wdog_to;
   } cfg_t;

   // latest measurement cycle result
   typedef struct packed {
      logic [11:0] adc;
      logic [15:0] temp;
   } sink_meas_t;

   localparam cfg_t CFG_RESET = '{enable: 1'b1, stab_arm: 1'b0, low_thr: RST_LOW_THR,
      high_thr: RST_HIGH_THR, max_chg: RST_MAX_CHG, fan_nom: RST_FAN_NOM,
      stab_to: RST_STAB_TO, wdog_to: RST_WDOG_TO};

endpackage

// [src/hold_timer.sv]
/*
 * hold_timer: counts ticks while a condition stays true and reports when
 * the count reaches a limit. Limit zero disables it.
 * Assumes cond and tick come from logic on the same clock.
 */
module hold_timer (
   input wire logic clk,              // system clock
   input wire logic rst_n,            // async reset, active low
   input wire logic cond,             // condition being timed
   input wire logic tick,             // count enable pulse
   input wire logic [31:0] limit,     // ticks to reach
   output logic hit                   // condition held long enough
);

   logic [31:0] cnt;

   // count while condition holds, drop to zero when it goes away
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 32'h0000_0000;
      end else if (!cond) begin
         cnt <= 32'h0000_0000;
      end else if (tick && cnt != limit) begin
         cnt <= cnt + 32'h0000_0001;
      end
   end

   // report
   assign hit = cond && (limit != 32'h0000_0000) && (cnt == limit);

endmodule

// [sim/tec_fault_chk.sv]
/* tec_fault_chk: port assertions for the fault monitor.
   assumes enable stays set and the watchdog stays off while sensor faults are provoked. */
module tec_fault_chk import tec_fault_pkg::*; #(
   parameter int unsigned FAN_STOP_LEN = 20 // fan stop hold cycles
) (
   input wire logic SYS_CLK_IN, // clock
   input wire logic RSTN_IN, // reset, active low
   input wire logic MEAS_VALID_IN, // sample strobe
   input wire logic [11:0] SINK_ADC_IN, // adc raw
   input wire logic TUNE_RUN_IN, // tuning active
   input wire logic REG_LIMIT_IN, // regulator limited
   input wire logic REG_RUN_IN, // regulator running
   input wire logic [7:0] FAN_PWM_IN, // fan pwm
   input wire logic [15:0] FAN_SPEED_IN, // fan speed
   input wire logic S_AXI_AWREADY_OUT, // write address ready
   input wire logic S_AXI_BVALID_OUT, // write response valid
   input wire logic S_AXI_ARREADY_OUT, // read address ready
   input wire logic S_AXI_RVALID_OUT, // read data valid
   input wire logic [7:0] ERR_CODE_OUT, // latched code
   input wire logic FAULT_OUT, // fault flag
   input wire logic HALT_OUT // halt
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   logic [7:0] stop_cnt;
   logic [7:0] next_stop_cnt;
   // run length of a driven but stopped fan, saturating
   assign next_stop_cnt = (FAN_SPEED_IN == 16'h0000 && FAN_PWM_IN > PWM_STOP_PCT) ?
      stop_cnt + 8'(stop_cnt != 8'hff) : 8'h00;
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) stop_cnt <= 8'h00;
      else stop_cnt <= next_stop_cnt;
   end
   // sensor, tuning and fan faults reach the latch in time
   property p_adc_low; MEAS_VALID_IN && SINK_ADC_IN < ADC_LOW_LIMIT && !FAULT_OUT |-> ##3 ERR_CODE_OUT == ERR_ADC_LOW; endproperty
   a_adc_low: assert property (p_adc_low) else $error("adc low not latched");
   property p_adc_high; MEAS_VALID_IN && SINK_ADC_IN > ADC_HIGH_LIMIT && !FAULT_OUT |-> ##3 FAULT_OUT; endproperty
   a_adc_high: assert property (p_adc_high) else $error("adc high not latched");
   property p_tune_reg; TUNE_RUN_IN && (REG_LIMIT_IN || !REG_RUN_IN) |-> ##2 FAULT_OUT; endproperty
   a_tune_reg: assert property (p_tune_reg) else $error("tuning fault not latched");
   property p_fan_stop; stop_cnt == 8'(FAN_STOP_LEN + 3) |-> FAULT_OUT; endproperty
   a_fan_stop: assert property (p_fan_stop) else $error("fan stop not latched");
   // latch consistency and bus exclusion
   property p_halt; HALT_OUT == FAULT_OUT; endproperty
   a_halt: assert property (p_halt) else $error("halt differs from fault");
   property p_fault_code; FAULT_OUT == (ERR_CODE_OUT != ERR_NONE); endproperty
   a_fault_code: assert property (p_fault_code) else $error("fault and code disagree");
   property p_code_hold; FAULT_OUT && $past(FAULT_OUT) && !S_AXI_BVALID_OUT |-> $stable(ERR_CODE_OUT); endproperty
   a_code_hold: assert property (p_code_hold) else $error("latched code changed");
   property p_b_busy; S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT; endproperty
   a_b_busy: assert property (p_b_busy) else $error("write taken during response");
   property p_r_busy; S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT; endproperty
   a_r_busy: assert property (p_r_busy) else $error("read taken during response");
endmodule
bind tec_fault_monitor tec_fault_chk #(.FAN_STOP_LEN(FAN_STOP_LEN)) chk_i (.*);

// [sim/testbench.sv]
/* testbench: register and fault scenarios for the fault monitor.
   assumes shortened tick and fan hold parameters and a 25 MHz clock. */
module testbench import tec_fault_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, meas = 0, t_run = 0, t_done = 0;
   logic r_lim = 0, r_run = 1, stable = 1, pkt = 0, aw_rdy, w_rdy, b_v, ar_rdy, r_v, fault, halt;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00, pwm = 8'h32, td = 8'h00, pd = 8'h00, code;
   logic [31:0] w_d = 32'h0000_0000, r_d;
   logic [11:0] adc = 12'h800;
   logic [15:0] temp = 16'h0000, spd = 16'h0bb8;
   logic [1:0] b_resp, r_resp;
   int failures = 0, n_checks = 0, cyc = 0;
   logic [7:0] ro [8] = '{OFS_CTRL, OFS_ERR, OFS_LOW_THR, OFS_HIGH_THR, OFS_MAX_CHG, OFS_FAN_NOM, OFS_STAB_TO, OFS_WDOG_TO};
   logic [15:0] rv [8] = '{16'h0001, 16'h0000, RST_LOW_THR, RST_HIGH_THR, RST_MAX_CHG, RST_FAN_NOM, 16'h0000, 16'h0000};
   logic [11:0] ca [7] = '{12'h027, 12'h028, 12'hfd3, 12'hfd2, 12'h800, 12'h800, 12'h027};
   logic [15:0] ct [7] = '{16'h0000, 16'hff00, 16'h0000, 16'h0500, 16'hfeff, 16'h0501, 16'hfeff};
   logic [7:0] ce [7] = '{ERR_ADC_LOW, ERR_NONE, ERR_ADC_HIGH, ERR_NONE, ERR_TEMP_LOW, ERR_TEMP_HIGH, ERR_ADC_LOW};
   tec_fault_monitor #(.TICK_LEN(4), .FAN_SLOW_LEN(20), .FAN_STOP_LEN(20)) DUT (
      .SYS_CLK_IN(clk), .RSTN_IN(rst_n), .S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v),
      .S_AXI_AWREADY_OUT(aw_rdy), .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(w_v),
      .S_AXI_WREADY_OUT(w_rdy), .S_AXI_BRESP_OUT(b_resp), .S_AXI_BVALID_OUT(b_v), .S_AXI_BREADY_IN(b_r),
      .S_AXI_ARADDR_IN(ar_a), .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_rdy), .S_AXI_RDATA_OUT(r_d),
      .S_AXI_RRESP_OUT(r_resp), .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(r_r), .MEAS_VALID_IN(meas),
      .SINK_ADC_IN(adc), .SINK_TEMP_IN(temp), .TUNE_RUN_IN(t_run), .TUNE_DONE_IN(t_done),
      .TUNE_TEMP_DISC_IN(td), .TUNE_PER_DISC_IN(pd), .REG_LIMIT_IN(r_lim), .REG_RUN_IN(r_run),
      .FAN_PWM_IN(pwm), .FAN_SPEED_IN(spd), .STABLE_IN(stable), .PKT_RX_IN(pkt),
      .ERR_CODE_OUT(code), .FAULT_OUT(fault), .HALT_OUT(halt));
   // clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   task report_and_stop;
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // bus cycles; each starts and ends just after a rising edge
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_rdy) aw_v <= 1'b0;
         if (w_rdy) w_v <= 1'b0;
      end while (b_v !== 1'b1);
      b_r <= 1'b0;
      chk(b_resp, er);
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
      do begin
         @(posedge clk);
         if (ar_rdy) ar_v <= 1'b0;
      end while (r_v !== 1'b1);
      r_r <= 1'b0;
      chk(r_d & 32'h0000_ffff, e);
      chk(r_resp, er);
      @(posedge clk);
   endtask
   // stimulus helpers and latch check with clear
   task mv(input logic [11:0] a, input logic [15:0] t);
      adc <= a; temp <= t; meas <= 1'b1;
      @(posedge clk);
      meas <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task tn(input logic [7:0] t, input logic [7:0] p);
      td <= t; pd <= p; t_done <= 1'b1;
      @(posedge clk);
      t_done <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task err(input logic [7:0] e);
      chk(code, e);
      chk(halt, e != ERR_NONE);
      rd(OFS_ERR, {23'h0, e != ERR_NONE, e}, RESP_OKAY);
      wr(OFS_ERR, 32'h0000_0100, RESP_OKAY);
   endtask
   task fan(input logic [7:0] p, input logic [15:0] s, input int n, input logic [7:0] e);
      pwm <= p; spd <= s;
      repeat (n) @(posedge clk);
      pwm <= 8'h32; spd <= 16'h0bb8;
      @(posedge clk);
      err(e);
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) rd(ro[i], {16'h0000, rv[i]}, RESP_OKAY);
      rd(8'h40, 32'h0000_0000, RESP_SLVERR);
      wr(8'h40, 32'h0000_0005, RESP_SLVERR);
      wr(OFS_COND, 32'h0000_0fff, RESP_OKAY);
      for (int i = 0; i < 7; i++) begin
         mv(ca[i], ct[i]);
         mv(12'h800, 16'h0000);
         err(ce[i]);
      end
      mv(12'h027, 16'h0000);
      mv(12'hfd3, 16'h0000);
      chk(code, ERR_ADC_LOW);
      wr(OFS_ERR, 32'h0000_0100, RESP_OKAY);
      mv(12'h800, 16'h0000);
      err(ERR_ADC_HIGH);
      for (int i = 0; i < 20; i++) mv(12'h800, 16'(i * 17));
      chk(code, ERR_NONE);
      mv(12'h800, 16'h0154);
      mv(12'h800, 16'h0154);
      err(ERR_TEMP_RATE);
      tn(8'h29, 8'h00); tn(8'h29, 8'h00); tn(8'h28, 8'h28); tn(8'h29, 8'h00); tn(8'h29, 8'h00);
      chk(code, ERR_NONE);
      tn(8'h29, 8'h29); tn(8'h00, 8'h00);
      err(ERR_TUNE_TEMP);
      tn(8'h00, 8'h29); tn(8'h00, 8'h29); tn(8'h00, 8'h29); tn(8'h00, 8'h00);
      err(ERR_TUNE_PERIOD);
      for (int i = 0; i < 2; i++) begin
         r_lim <= i[0]; r_run <= i[0]; t_run <= 1'b1;
         repeat (3) @(posedge clk);
         t_run <= 1'b0; r_lim <= 1'b0; r_run <= 1'b1;
         @(posedge clk);
         err(ERR_TUNE_REG);
      end
      fan(8'h24, 16'h0000, 19, ERR_NONE);
      fan(8'h24, 16'h0000, 25, ERR_FAN_STOP);
      fan(8'h23, 16'h0000, 25, ERR_NONE);
      fan(8'h64, 16'h0707, 25, ERR_FAN_SLOW);
      fan(8'h64, 16'h0708, 25, ERR_NONE);
      wr(OFS_STAB_TO, 32'h0000_0003, RESP_OKAY);
      stable <= 1'b0;
      wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
      repeat (5) @(posedge clk);
      chk(code, ERR_NONE);
      repeat (12) @(posedge clk);
      stable <= 1'b1;
      wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
      err(ERR_STAB);
      wr(OFS_WDOG_TO, 32'h0000_0002, RESP_OKAY);
      repeat (10) begin
         pkt <= 1'b1;
         @(posedge clk);
         pkt <= 1'b0;
         @(posedge clk);
      end
      chk(code, ERR_NONE);
      repeat (16) @(posedge clk);
      wr(OFS_WDOG_TO, 32'h0000_0000, RESP_OKAY);
      err(ERR_WDOG);
      report_and_stop();
   end
endmodule
